// File: hw/usp_defines.vh
// Constants for the buffered serial port
`ifndef USP_DEFINES_VH
`define USP_DEFINES_VH
`define USP_CLK_HZ 200000000
`define USP_DEBUG_BAUD 19200
`define USP_RX_DEPTH 256
`define USP_TOTAL_DEPTH_MAX 6144
`define USP_PORT_MIN 2'h1
`define USP_PORT_MAX 2'h3
`define USP_OVS 16
`define USP_DIV_RST 16'h028b
`define USP_DATA_BITS 8
`endif

// File: hw/usp_rx_fifo.v
// Receive buffer with count, flush and overflow flag
`timescale 1ns/1ps
`default_nettype none
`include "usp_defines.vh"
module usp_rx_fifo #(
  parameter DEPTH = `USP_RX_DEPTH,
  parameter AW = 8
) (
  input wire i_clk, // System clock
  input wire i_rst_n, // Async reset, active low
  input wire i_wr, // Received character strobe
  input wire [7:0] i_wdata, // Received character
  input wire i_rd, // Pop one character
  input wire i_flush, // Discard all contents
  input wire i_ovf_clr, // Overflow was reported
  output reg [7:0] o_rdata, // Character popped
  output wire [AW:0] o_count, // Stored character count
  output reg o_ovf // Overflow seen
);
  reg [7:0] mem [0:DEPTH-1];
  reg [AW-1:0] wp_reg;
  reg [AW-1:0] rp_reg;
  reg [AW:0] cnt_reg;
  wire full = (cnt_reg == DEPTH[AW:0]);
  wire do_wr = i_wr & ~full & ~i_flush;
  wire do_rd = i_rd & (cnt_reg != {(AW+1){1'b0}}) & ~i_flush;
  assign o_count = cnt_reg;
  always @(posedge i_clk) begin
    if (do_wr) begin
      mem[wp_reg] <= i_wdata;
    end
  end
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp_reg <= {AW{1'b0}};
      rp_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
      o_rdata <= 8'h00;
      o_ovf <= 1'b0;
    end else begin
      if (i_flush) begin
        wp_reg <= {AW{1'b0}};
        rp_reg <= {AW{1'b0}};
        cnt_reg <= {(AW+1){1'b0}};
      end else begin
        if (do_wr) begin
          wp_reg <= wp_reg + 1'b1;
        end
        if (do_rd) begin
          rp_reg <= rp_reg + 1'b1;
          o_rdata <= mem[rp_reg];
        end
        cnt_reg <= cnt_reg + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
      end
      // Set beats i_ovf_clr but not i_flush, so a report never hides a lost character
      if (i_wr & full & ~i_flush) begin
        o_ovf <= 1'b1;
      end else if (i_flush | i_ovf_clr) begin
        o_ovf <= 1'b0;
      end
    end
  end
endmodule // usp_rx_fifo
`default_nettype wire

// File: hw/usp_serial_port.v
// Buffered asynchronous serial port top level
`timescale 1ns/1ps
`default_nettype none
`include "usp_defines.vh"
module usp_serial_port #(
  parameter RX_DEPTH = `USP_RX_DEPTH,
  parameter RX_AW = 8,
  parameter PORT_ID = 2'h1,
  parameter DEBUG_START = 1'b0
) (
  input wire i_clk, // 200 MHz system clock
  input wire i_rst_n, // Async reset, active low
  input wire i_cfg_valid, // Configure rate strobe
  input wire [1:0] i_cfg_port, // Port index 1..3
  input wire [15:0] i_cfg_div, // Clocks per sixteenth of a bit
  input wire i_enable, // Port enable strobe
  input wire i_disable, // Port disable strobe
  input wire i_flush, // Discard receive buffer
  input wire i_fetch, // Pop one received character
  input wire i_fetch_done, // Fetch sequence finished, clears overflow
  input wire i_tx_valid, // Character to send is valid
  input wire [7:0] i_tx_data, // Character to send
  input wire i_tx_string, // Null ends the send, not transmitted
  input wire i_rxd, // Serial receive line
  output wire o_tx_ready, // Transmitter accepts a character
  output reg o_txd, // Serial transmit line
  output wire [7:0] o_rx_data, // Last fetched character
  output wire [RX_AW:0] o_rx_count, // Stored character count
  output wire o_rx_overflow, // Overflow seen, fetch result negative
  output reg o_enabled, // Port running
  output reg o_cfg_err // Last configure had a bad index
);
  localparam integer DBG_DIV_FULL = `USP_CLK_HZ / (`USP_DEBUG_BAUD * `USP_OVS);
  localparam [15:0] DBG_DIV = DBG_DIV_FULL[15:0];
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_START = 4'h2;
  localparam [3:0] ST_DATA = 4'h4;
  localparam [3:0] ST_STOP = 4'h8;
  reg [15:0] div_reg;
  reg [15:0] tick_cnt_reg;
  reg tick_reg;
  wire cfg_ok = (i_cfg_port >= `USP_PORT_MIN) && (i_cfg_port <= `USP_PORT_MAX);
  wire cfg_mine = i_cfg_valid & cfg_ok & (i_cfg_port == PORT_ID);
  // Configuration and enable; debug option starts at a fixed rate already running
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_reg <= DEBUG_START ? DBG_DIV : `USP_DIV_RST;
      o_enabled <= DEBUG_START;
      o_cfg_err <= 1'b0;
    end else begin
      if (i_cfg_valid) begin
        o_cfg_err <= ~cfg_ok;
      end
      if (cfg_mine) begin
        div_reg <= (i_cfg_div == 16'h0000) ? 16'h0001 : i_cfg_div;
      end
      if (i_disable) begin
        o_enabled <= 1'b0;
      end else if (i_enable) begin
        o_enabled <= 1'b1;
      end
    end
  end
  // Oversample tick divider, one-cycle enable
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (!o_enabled || cfg_mine) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (tick_cnt_reg >= div_reg - 16'h0001) begin
      tick_cnt_reg <= 16'h0000;
      tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end
  // Receiver: centre samples at 16x oversampling
  reg [3:0] rx_st_reg;
  reg [3:0] rx_ph_reg;
  reg [2:0] rx_bit_reg;
  reg [7:0] rx_sh_reg;
  reg rx_done_reg;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_st_reg <= ST_IDLE;
      rx_ph_reg <= 4'h0;
      rx_bit_reg <= 3'h0;
      rx_sh_reg <= 8'h00;
      rx_done_reg <= 1'b0;
    end else begin
      rx_done_reg <= 1'b0;
      if (!o_enabled) begin
        rx_st_reg <= ST_IDLE;
      end else if (tick_reg) begin
        rx_ph_reg <= rx_ph_reg + 4'h1;
        case (rx_st_reg)
          ST_IDLE: begin
            rx_ph_reg <= 4'h0;
            if (!i_rxd) begin
              rx_st_reg <= ST_START;
            end
          end
          ST_START: begin
            if (rx_ph_reg == 4'h7) begin
              rx_ph_reg <= 4'h0;
              rx_bit_reg <= 3'h0;
              // A glitch shorter than half a bit is not a start
              rx_st_reg <= i_rxd ? ST_IDLE : ST_DATA;
            end
          end
          ST_DATA: begin
            if (rx_ph_reg == 4'hf) begin
              rx_sh_reg <= {i_rxd, rx_sh_reg[7:1]};
              rx_bit_reg <= rx_bit_reg + 3'h1;
              if (rx_bit_reg == 3'h7) begin
                rx_st_reg <= ST_STOP;
              end
            end
          end
          ST_STOP: begin
            if (rx_ph_reg == 4'hf) begin
              rx_st_reg <= ST_IDLE;
              rx_done_reg <= i_rxd;
            end
          end
          default: begin
            rx_st_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end
  // Framing errors drop the character; only overflow is reported
  usp_rx_fifo #(
    .DEPTH(RX_DEPTH),
    .AW(RX_AW)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_wr(rx_done_reg),
    .i_wdata(rx_sh_reg),
    .i_rd(i_fetch),
    .i_flush(i_flush),
    .i_ovf_clr(i_fetch_done),
    .o_rdata(o_rx_data),
    .o_count(o_rx_count),
    .o_ovf(o_rx_overflow)
  );
  // Transmitter
  reg [3:0] tx_st_reg;
  reg [3:0] tx_ph_reg;
  reg [2:0] tx_bit_reg;
  reg [7:0] tx_sh_reg;
  assign o_tx_ready = o_enabled & (tx_st_reg == ST_IDLE);
  wire tx_take = o_tx_ready & i_tx_valid;
  wire tx_null = i_tx_string & (i_tx_data == 8'h00);
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_st_reg <= ST_IDLE;
      tx_ph_reg <= 4'h0;
      tx_bit_reg <= 3'h0;
      tx_sh_reg <= 8'h00;
      o_txd <= 1'b1;
    end else if (!o_enabled) begin
      tx_st_reg <= ST_IDLE;
      o_txd <= 1'b1;
    end else begin
      case (tx_st_reg)
        ST_IDLE: begin
          o_txd <= 1'b1;
          tx_ph_reg <= 4'h0;
          // Terminator is consumed but never framed
          if (tx_take && !tx_null) begin
            tx_sh_reg <= i_tx_data;
            tx_st_reg <= ST_START;
          end
        end
        ST_START: begin
          o_txd <= 1'b0;
          if (tick_reg) begin
            tx_ph_reg <= tx_ph_reg + 4'h1;
            if (tx_ph_reg == 4'hf) begin
              tx_bit_reg <= 3'h0;
              tx_st_reg <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          o_txd <= tx_sh_reg[0];
          if (tick_reg) begin
            tx_ph_reg <= tx_ph_reg + 4'h1;
            if (tx_ph_reg == 4'hf) begin
              tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
              tx_bit_reg <= tx_bit_reg + 3'h1;
              if (tx_bit_reg == 3'h7) begin
                tx_st_reg <= ST_STOP;
              end
            end
          end
        end
        ST_STOP: begin
          o_txd <= 1'b1;
          if (tick_reg) begin
            tx_ph_reg <= tx_ph_reg + 4'h1;
            if (tx_ph_reg == 4'hf) begin
              tx_st_reg <= ST_IDLE;
            end
          end
        end
        default: begin
          tx_st_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // usp_serial_port
`default_nettype wire

// File: sim/usp_serial_port_monitor.sv
// Concurrent checks on the serial port top
`timescale 1ns/1ps
`default_nettype none
module usp_serial_port_chk #(
  parameter RX_DEPTH = 256,
  parameter RX_AW = 8
) (
  input wire logic i_clk, // Clock
  input wire logic i_rst_n, // Reset, active low
  input wire logic i_enable, // Enable strobe
  input wire logic i_disable, // Disable strobe
  input wire logic i_flush, // Flush strobe
  input wire logic i_fetch, // Fetch strobe
  input wire logic i_fetch_done, // Overflow report strobe
  input wire logic i_tx_valid, // Send valid
  input wire logic [7:0] i_tx_data, // Send data
  input wire logic i_tx_string, // String mode
  input wire logic o_tx_ready, // Transmitter idle
  input wire logic o_txd, // Serial out
  input wire logic [RX_AW:0] o_rx_count, // Stored count
  input wire logic o_rx_overflow, // Overflow flag
  input wire logic o_enabled // Port running
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_take;
    o_tx_ready && i_tx_valid && !(i_tx_string && i_tx_data == 8'h00);
  endsequence
  sequence s_start;
    !o_txd && !o_tx_ready;
  endsequence
  a_tx_start_bit: assert property (s_take |=> !o_tx_ready ##1 s_start) else $error("no start bit");
  a_null_unsent: assert property (o_tx_ready && i_tx_valid && i_tx_string && i_tx_data == 8'h00
    |=> o_txd) else $error("null was sent");
  a_enable_on: assert property (i_enable && !i_disable |=> o_enabled) else $error("not on");
  a_disable_off: assert property (i_disable |=> !o_enabled) else $error("not off");
  a_count_bound: assert property (o_rx_count <= RX_DEPTH) else $error("count too big");
  a_fetch_pop: assert property (i_fetch && o_rx_count != 0 && !i_flush
    |=> o_rx_count == $past(o_rx_count) - 1'b1 || o_rx_count == $past(o_rx_count))
    else $error("bad pop");
  a_flush_empty: assert property (i_flush |=> o_rx_count == 0) else $error("flush kept");
  a_ovf_hold: assert property (o_rx_overflow && !i_fetch_done && !i_flush |=> o_rx_overflow)
    else $error("ovf lost");
  a_ovf_clear: assert property ((i_fetch_done || i_flush) && o_rx_count < RX_DEPTH
    |=> !o_rx_overflow) else $error("ovf stuck");
  a_ovf_full: assert property ($rose(o_rx_overflow) |-> $past(o_rx_count) == RX_DEPTH)
    else $error("ovf early");
endmodule // usp_serial_port_chk
bind usp_serial_port usp_serial_port_chk #(.RX_DEPTH(RX_DEPTH), .RX_AW(RX_AW)) u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_enable(i_enable), .i_disable(i_disable),
  .i_flush(i_flush), .i_fetch(i_fetch), .i_fetch_done(i_fetch_done), .i_tx_valid(i_tx_valid),
  .i_tx_data(i_tx_data), .i_tx_string(i_tx_string), .o_tx_ready(o_tx_ready), .o_txd(o_txd),
  .o_rx_count(o_rx_count), .o_rx_overflow(o_rx_overflow), .o_enabled(o_enabled));
`default_nettype wire

// File: sim/usp_far_device.sv
// Far-side serial device model
`timescale 1ns/1ps
`default_nettype none
module usp_far_device #(
  parameter int BIT_CLKS = 16
) (
  input wire logic i_clk, // Clock
  input wire logic i_txd, // Line from port
  output logic o_rxd = 1'b1 // Line into port, idles high
);
  // Bit length the bench may change to follow a rate change
  int bit_clks = BIT_CLKS;
  logic [9:0] fr;
  logic [9:0] rx_q [$];
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge i_clk);
      o_rxd <= f[i];
      repeat (bit_clks - 1) @(posedge i_clk);
    end
  endtask
  // Mid-bit sampling tolerates a cycle of skew at either bit edge
  always begin
    @(negedge i_txd);
    repeat (bit_clks / 2) @(posedge i_clk);
    for (int i = 0; i < 10; i++) begin
      fr[i] = i_txd;
      if (i < 9) repeat (bit_clks) @(posedge i_clk);
    end
    rx_q.push_back(fr);
  end
endmodule // usp_far_device
`default_nettype wire

// File: sim/usp_serial_port_test.sv
// Self-checking bench for the buffered serial port
`timescale 1ns/1ps
`default_nettype none
module usp_serial_port_test;
  localparam int DEPTH = 4;
  localparam int BITC = 16; // Divider of 1 gives 16 clocks a bit
  typedef struct packed {logic [7:0] d; logic s; logic sent;} usp_row_t;
  usp_row_t rows [5] = '{'{8'h55, 1'b0, 1'b1}, '{8'ha3, 1'b1, 1'b1}, '{8'h00, 1'b1, 1'b0},
    '{8'h00, 1'b0, 1'b1}, '{8'hff, 1'b0, 1'b1}};
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [5:0] st = 6'h00;
  logic [1:0] port = 2'h0;
  logic tx_v = 1'b0;
  logic [7:0] tx_d = 8'h00;
  logic tx_s = 1'b0;
  logic [15:0] div = 16'h0001;
  wire en_dbg, rdy_dbg;
  wire rxd, txd, rdy, ovf, en, cerr;
  wire [7:0] rdat;
  wire [2:0] cnt;
  int error_cnt = 0;
  int checked = 0;
  always #2.5 i_clk = ~i_clk;
  usp_serial_port #(.RX_DEPTH(DEPTH), .RX_AW(2)) u_usp_serial_port (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_cfg_valid(st[0]), .i_cfg_port(port), .i_cfg_div(div),
    .i_enable(st[1]), .i_disable(st[2]), .i_flush(st[3]), .i_fetch(st[4]),
    .i_fetch_done(st[5]), .i_tx_valid(tx_v), .i_tx_data(tx_d), .i_tx_string(tx_s),
    .i_rxd(rxd), .o_tx_ready(rdy), .o_txd(txd), .o_rx_data(rdat), .o_rx_count(cnt),
    .o_rx_overflow(ovf), .o_enabled(en), .o_cfg_err(cerr));
  usp_far_device #(.BIT_CLKS(BITC)) u_usp_far_device (.i_clk(i_clk), .i_txd(txd), .o_rxd(rxd));
  // Second port built with the debug start option; only its startup state is checked
  usp_serial_port #(.RX_DEPTH(DEPTH), .RX_AW(2), .DEBUG_START(1'b1)) u_usp_serial_port_dbg (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cfg_valid(1'b0), .i_cfg_port(2'h0),
    .i_cfg_div(16'h0000), .i_enable(1'b0), .i_disable(1'b0), .i_flush(1'b0), .i_fetch(1'b0),
    .i_fetch_done(1'b0), .i_tx_valid(1'b0), .i_tx_data(8'h00), .i_tx_string(1'b0),
    .i_rxd(1'b1), .o_tx_ready(rdy_dbg), .o_txd(), .o_rx_data(), .o_rx_count(),
    .o_rx_overflow(), .o_enabled(en_dbg), .o_cfg_err());
  task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic strobe(input int b, input logic [1:0] p = 2'h1);
    @(posedge i_clk);
    st[b] <= 1'b1;
    port <= p;
    @(posedge i_clk);
    st <= 6'h00;
    @(negedge i_clk);
  endtask
  task automatic send(input logic [7:0] d, input logic s);
    @(posedge i_clk);
    tx_v <= 1'b1;
    tx_d <= d;
    tx_s <= s;
    @(negedge i_clk);
    for (int k = 0; k < 400 && rdy !== 1'b1; k++) @(negedge i_clk);
    @(posedge i_clk);
    tx_v <= 1'b0;
  endtask
  task automatic summarize();
    $display("Counts: %0d checked, %0d errors", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(negedge i_clk);
    cmp({cnt, ovf, en, cerr, txd}, 10'h001);
    cmp({en_dbg, rdy_dbg}, 2'h3);
    strobe(0, 2'h0);
    cmp(cerr, 1'b1);
    strobe(0, 2'h3);
    cmp(cerr, 1'b0);
    strobe(0);
    cmp(cerr, 1'b0);
    strobe(1);
    cmp({en, rdy}, 2'h3);
    $display("Test setup done");
    foreach (rows[i]) begin
      send(rows[i].d, rows[i].s);
      repeat (12 * BITC) @(negedge i_clk);
      cmp(10'(u_usp_far_device.rx_q.size()), rows[i].sent);
      if (rows[i].sent) cmp(u_usp_far_device.rx_q.pop_front(), {1'b1, rows[i].d, 1'b0});
    end
    $display("Test tx done");
    for (int i = 0; i < 3; i++) u_usp_far_device.send(8'h30 + i[7:0]);
    @(negedge i_clk);
    cmp(cnt, 3);
    for (int i = 0; i < 3; i++) begin
      strobe(4);
      cmp(rdat, 8'h30 + i[7:0]);
    end
    cmp(cnt, 0);
    for (int i = 0; i < 5; i++) u_usp_far_device.send(8'h40 + i[7:0]);
    @(negedge i_clk);
    cmp({cnt, ovf}, {3'(DEPTH), 1'b1});
    strobe(4);
    cmp({rdat, ovf}, {8'h40, 1'b1});
    strobe(5);
    cmp(ovf, 1'b0);
    strobe(3);
    cmp(cnt, 0);
    $display("Test rx done");
    strobe(2);
    cmp(en, 1'b0);
    u_usp_far_device.send(8'h99);
    @(negedge i_clk);
    cmp(cnt, 0);
    // Rate change while disabled: both ends move to twice the bit length
    @(posedge i_clk);
    div <= 16'h0002;
    strobe(0);
    strobe(1);
    cmp(en, 1'b1);
    u_usp_far_device.bit_clks = 2 * BITC;
    u_usp_far_device.send(8'h5a);
    @(negedge i_clk);
    cmp(cnt, 1);
    strobe(4);
    cmp(rdat, 8'h5a);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    @(negedge i_clk);
    cmp({cnt, en, txd}, 10'h001);
    $display("Test reset done");
    summarize();
  end
endmodule // usp_serial_port_test
`default_nettype wire
